// File: csreg_bus_model.sv
// Purpose: data-space bus partner of the core
// Assumes: tasks entered just after a falling edge
// Notes: released write data shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module csreg_bus_model (
	// clock
	input wire logic clk_i,
	// bus toward the core
	output logic [7:0] dbus_addr_o, dbus_wdata_o,
	output logic [1:0] dbus_short_sel_o,
	output logic dbus_short_o, dbus_rd_o, dbus_wr_o,
	// answer from the core
	input wire logic [7:0] dbus_rdata_i,
	input wire logic dbus_hit_i
);
	initial {dbus_addr_o, dbus_wdata_o, dbus_short_sel_o} = '0;
	initial {dbus_short_o, dbus_rd_o, dbus_wr_o} = 3'h0;
	task acc(input logic w, s, input logic [1:0] l, input logic [7:0] a, d,
		output logic [7:0] q, output logic h);
		{dbus_wr_o, dbus_rd_o, dbus_short_o} = {w, !w, s};
		dbus_short_sel_o = l;
		dbus_addr_o = a;
		dbus_wdata_o = d;
		@(negedge clk_i);
		q = dbus_rdata_i;
		h = dbus_hit_i;
		{dbus_wr_o, dbus_rd_o} = 2'h0;
		dbus_wdata_o = ~d;
		@(negedge clk_i);
	endtask
endmodule
`default_nettype wire

// File: csreg_checker.sv
// Purpose: port-level timing checks of the core register set
// Assumes: one clock, synchronous active-high reset
// Notes: bound into csreg_core
`timescale 1ns/1ps
`default_nettype none
module csreg_checker (
	// watched ports
	input wire logic clk_i, sys_rst_i,
	input wire logic dbus_short_i, dbus_rd_i, dbus_wr_i, alu_wr_i,
	input wire logic flag_we_i, dbus_hit_o, carry_o, zero_o,
	input wire logic [7:0] dbus_addr_i, dbus_rdata_o, branch_off_i, work_o,
	input wire logic [3:0] pc_op_i,
	input wire logic [11:0] pc_target_i, pc_o,
	input wire logic [1:0] ctx_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	wire logic mapped = dbus_addr_i inside {8'h80, 8'h81, 8'h82, 8'h83,
		8'hff};
	wire logic [11:0] br = pc_o + {{4{branch_off_i[7]}}, branch_off_i};
	sequence s_rd;
		dbus_rd_i && !dbus_short_i;
	endsequence
	sequence s_call;
		pc_op_i == 4'h3;
	endsequence
	a_rd_mapped: assert property (s_rd ##0 mapped |=> dbus_hit_o)
		else $error("no hit after mapped read");
	a_miss_zero: assert property (s_rd ##0 !mapped
		|=> !dbus_hit_o && dbus_rdata_o == 8'h00)
		else $error("unmapped read answered");
	a_work_read: assert property (s_rd ##0 dbus_addr_i == 8'hff
		&& !alu_wr_i |=> dbus_rdata_o == $past(work_o))
		else $error("work read wrong");
	a_pc_inc: assert property (pc_op_i == 4'h1
		|=> pc_o == $past(pc_o) + 12'h001)
		else $error("increment wrong");
	a_pc_branch: assert property (pc_op_i == 4'h4
		|=> pc_o == $past(br))
		else $error("branch sum wrong");
	a_call_target: assert property (s_call
		|=> pc_o == $past(pc_target_i))
		else $error("call target wrong");
	a_int_ctx: assert property (pc_op_i == 4'h5 |=> ctx_o == 2'h1)
		else $error("interrupt context wrong");
	a_flag_keep: assert property (!flag_we_i
		&& !(pc_op_i inside {4'h5, 4'h6, 4'h8})
		|=> $stable({carry_o, zero_o})) else $error("flags moved");
	a_reset_nmi: assert property (disable iff (1'b0) sys_rst_i
		|=> ctx_o == 2'h2 && pc_o == 12'h0ffe) else $error("reset state wrong");
endmodule
bind csreg_core csreg_checker csreg_checker_i (
	.clk_i(clk_i),
	.sys_rst_i(sys_rst_i),
	.dbus_short_i(dbus_short_i),
	.dbus_rd_i(dbus_rd_i),
	.dbus_wr_i(dbus_wr_i),
	.alu_wr_i(alu_wr_i),
	.flag_we_i(flag_we_i),
	.dbus_hit_o(dbus_hit_o),
	.carry_o(carry_o),
	.zero_o(zero_o),
	.dbus_addr_i(dbus_addr_i),
	.dbus_rdata_o(dbus_rdata_o),
	.branch_off_i(branch_off_i),
	.work_o(work_o),
	.pc_op_i(pc_op_i),
	.pc_target_i(pc_target_i),
	.pc_o(pc_o),
	.ctx_o(ctx_o)
);
`default_nettype wire

// File: csreg_core.sv
// Purpose: programmer-visible register set of an 8-bit core
// Assumes: sequencer on the same clock drives all requests
// Notes: data-space reads answer one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module csreg_core #(
	parameter int PAGE_W = 2
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// data-space register bus
	input wire logic [7:0] dbus_addr_i,
	input wire logic dbus_short_i,
	input wire logic [1:0] dbus_short_sel_i,
	input wire logic dbus_rd_i,
	input wire logic dbus_wr_i,
	input wire logic [7:0] dbus_wdata_i,
	output logic [7:0] dbus_rdata_o,
	output logic dbus_hit_o,
	// alu result and flags
	input wire logic alu_wr_i,
	input wire logic [7:0] alu_result_i,
	input wire logic flag_we_i,
	input wire logic carry_i,
	input wire logic zero_i,
	output logic carry_o,
	output logic zero_o,
	// program counter control
	input wire logic [3:0] pc_op_i,
	input wire logic [11:0] pc_target_i,
	input wire logic [7:0] branch_off_i,
	input wire logic [1:0] int_sel_i,
	// program page
	input wire logic page_wr_i,
	input wire logic [PAGE_W-1:0] page_i,
	// register views
	output logic [7:0] work_o,
	output logic [7:0] ptr_one_o,
	output logic [7:0] ptr_two_o,
	output logic [7:0] sd_one_o,
	output logic [7:0] sd_two_o,
	output logic [11:0] pc_o,
	output logic [PAGE_W+11:0] prog_addr_o,
	output logic [1:0] ctx_o
);
	typedef struct packed {
		logic [7:0] work;
		logic [7:0] ptr_one;
		logic [7:0] ptr_two;
		logic [7:0] sd_one;
		logic [7:0] sd_two;
		logic [11:0] pc;
		logic [PAGE_W-1:0] page;
		logic [2:0] carry;
		logic [2:0] zero;
		csreg_pkg::csreg_ctx_t ctx;
		csreg_pkg::csreg_ctx_t prior;
		logic [7:0] rdata;
		logic hit;
		logic cur_c;
		logic cur_z;
	} csreg_core_t;

	csreg_core_t st_r;
	csreg_core_t st_nxt;
	logic stk_push;
	logic stk_pop;
	logic [11:0] stk_top;
	logic stk_empty;
	logic [11:0] pc_plus1;
	logic [7:0] eff_addr;

	initial begin
		if (PAGE_W < 1 || PAGE_W > 8)
			$error("page width out of range");
		if (csreg_pkg::PC_W != 12)
			$error("counter width must stay twelve");
		if (csreg_pkg::DATA_W != 8)
			$error("data width must stay eight");
		if (csreg_pkg::STACK_DEPTH < 2)
			$error("return stack too shallow");
	end

	function automatic logic [7:0] short_addr(input logic [1:0] sel);
		logic [7:0] a;
		a = csreg_pkg::ADDR_PTR_ONE;
		if (sel == 2'd1)
			a = csreg_pkg::ADDR_PTR_TWO;
		else if (sel == 2'd2)
			a = csreg_pkg::ADDR_SD_ONE;
		else if (sel == 2'd3)
			a = csreg_pkg::ADDR_SD_TWO;
		return a;
	endfunction

	function automatic logic [11:0] pc_add(input logic [11:0] pc,
		input logic [7:0] off);
		logic [11:0] ext;
		ext = {{4{off[7]}}, off};
		return pc + ext;
	endfunction

	function automatic logic [11:0] int_vec(input logic [1:0] sel);
		return csreg_pkg::INT_VEC_BASE + {9'h000, sel, 1'b0};
	endfunction

	function automatic logic [1:0] ctx_idx(input csreg_pkg::csreg_ctx_t c);
		return 2'(c);
	endfunction

	assign eff_addr = dbus_short_i ? short_addr(dbus_short_sel_i)
		: dbus_addr_i;
	assign pc_plus1 = st_r.pc + 12'h001;

	assign stk_push = (pc_op_i == 4'(csreg_pkg::CSREG_PC_CALL))
		|| (pc_op_i == 4'(csreg_pkg::CSREG_PC_INT))
		|| (pc_op_i == 4'(csreg_pkg::CSREG_PC_NMI));
	assign stk_pop = (pc_op_i == 4'(csreg_pkg::CSREG_PC_RET))
		|| (pc_op_i == 4'(csreg_pkg::CSREG_PC_RETURN_FROM_INTERRUPT_OP));

	always_comb begin
		st_nxt = st_r;
		st_nxt.hit = 1'b0;
		st_nxt.rdata = csreg_pkg::RESET_DATA;
		if (dbus_rd_i || dbus_wr_i) begin
			if (eff_addr == csreg_pkg::ADDR_PTR_ONE) begin
				st_nxt.hit = 1'b1;
				st_nxt.rdata = st_r.ptr_one;
			end else if (eff_addr == csreg_pkg::ADDR_PTR_TWO) begin
				st_nxt.hit = 1'b1;
				st_nxt.rdata = st_r.ptr_two;
			end else if (eff_addr == csreg_pkg::ADDR_SD_ONE) begin
				st_nxt.hit = 1'b1;
				st_nxt.rdata = st_r.sd_one;
			end else if (eff_addr == csreg_pkg::ADDR_SD_TWO) begin
				st_nxt.hit = 1'b1;
				st_nxt.rdata = st_r.sd_two;
			end else if (eff_addr == csreg_pkg::ADDR_WORK) begin
				st_nxt.hit = 1'b1;
				st_nxt.rdata = st_r.work;
			end
			if (!dbus_rd_i)
				st_nxt.rdata = csreg_pkg::RESET_DATA;
		end
		if (dbus_wr_i) begin
			if (eff_addr == csreg_pkg::ADDR_PTR_ONE)
				st_nxt.ptr_one = dbus_wdata_i;
			else if (eff_addr == csreg_pkg::ADDR_PTR_TWO)
				st_nxt.ptr_two = dbus_wdata_i;
			else if (eff_addr == csreg_pkg::ADDR_SD_ONE)
				st_nxt.sd_one = dbus_wdata_i;
			else if (eff_addr == csreg_pkg::ADDR_SD_TWO)
				st_nxt.sd_two = dbus_wdata_i;
			else if (eff_addr == csreg_pkg::ADDR_WORK)
				st_nxt.work = dbus_wdata_i;
		end
		if (alu_wr_i)
			st_nxt.work = alu_result_i;
		if (page_wr_i)
			st_nxt.page = page_i;

		if (flag_we_i) begin
			st_nxt.carry[ctx_idx(st_r.ctx)] = carry_i;
			st_nxt.zero[ctx_idx(st_r.ctx)] = zero_i;
		end

		case (pc_op_i)
			4'(csreg_pkg::CSREG_PC_INC): begin
				st_nxt.pc = pc_plus1;
			end
			4'(csreg_pkg::CSREG_PC_JUMP),
			4'(csreg_pkg::CSREG_PC_CALL): begin
				st_nxt.pc = pc_target_i;
			end
			4'(csreg_pkg::CSREG_PC_BRANCH): begin
				st_nxt.pc = pc_add(st_r.pc, branch_off_i);
			end
			4'(csreg_pkg::CSREG_PC_INT): begin
				st_nxt.pc = int_vec(int_sel_i);
				st_nxt.prior = st_r.ctx;
				st_nxt.ctx = csreg_pkg::CSREG_CTX_INT;
			end
			4'(csreg_pkg::CSREG_PC_NMI): begin
				st_nxt.pc = csreg_pkg::NMI_VEC;
				st_nxt.prior = st_r.ctx;
				st_nxt.ctx = csreg_pkg::CSREG_CTX_NMI;
			end
			4'(csreg_pkg::CSREG_PC_RET),
			4'(csreg_pkg::CSREG_PC_RETURN_FROM_INTERRUPT_OP): begin
				st_nxt.pc = stk_empty ? pc_plus1 : stk_top;
				if (pc_op_i == 4'(csreg_pkg::CSREG_PC_RETURN_FROM_INTERRUPT_OP)) begin
					st_nxt.ctx = st_r.prior;
					st_nxt.prior = csreg_pkg::CSREG_CTX_NORMAL;
				end
			end
			default: begin
				st_nxt.pc = st_r.pc;
			end
		endcase

		st_nxt.cur_c = st_nxt.carry[ctx_idx(st_nxt.ctx)];
		st_nxt.cur_z = st_nxt.zero[ctx_idx(st_nxt.ctx)];
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_r.work <= csreg_pkg::RESET_DATA;
			st_r.ptr_one <= csreg_pkg::RESET_DATA;
			st_r.ptr_two <= csreg_pkg::RESET_DATA;
			st_r.sd_one <= csreg_pkg::RESET_DATA;
			st_r.sd_two <= csreg_pkg::RESET_DATA;
			st_r.pc <= csreg_pkg::RESET_VEC;
			st_r.page <= '0;
			st_r.carry <= '0;
			st_r.zero <= '0;
			st_r.ctx <= csreg_pkg::CSREG_CTX_NMI;
			st_r.prior <= csreg_pkg::CSREG_CTX_NORMAL;
			st_r.rdata <= csreg_pkg::RESET_DATA;
			st_r.hit <= 1'b0;
			st_r.cur_c <= 1'b0;
			st_r.cur_z <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	csreg_stack #(
		.DEPTH(csreg_pkg::STACK_DEPTH),
		.WIDTH(csreg_pkg::PC_W)
	) csreg_stack_i (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.push_i(stk_push),
		.pop_i(stk_pop),
		.push_data_i(st_r.pc),
		.top_o(stk_top),
		.empty_o(stk_empty)
	);

	assign dbus_rdata_o = st_r.rdata;
	assign dbus_hit_o = st_r.hit;
	assign carry_o = st_r.cur_c;
	assign zero_o = st_r.cur_z;
	assign work_o = st_r.work;
	assign ptr_one_o = st_r.ptr_one;
	assign ptr_two_o = st_r.ptr_two;
	assign sd_one_o = st_r.sd_one;
	assign sd_two_o = st_r.sd_two;
	assign pc_o = st_r.pc;
	assign prog_addr_o = {st_r.page, st_r.pc};
	assign ctx_o = 2'(st_r.ctx);
endmodule
`default_nettype wire

// File: csreg_pkg.sv
// Purpose: shared constants and types of the core register set
// Assumes: 8-bit data space, 12-bit program space
// Notes: vector addresses are the low byte of each two-byte vector slot
package csreg_pkg;
	localparam int DATA_W = 8;
	localparam int PC_W = 12;
	localparam logic [7:0] ADDR_PTR_ONE = 8'h80;
	localparam logic [7:0] ADDR_PTR_TWO = 8'h81;
	localparam logic [7:0] ADDR_SD_ONE = 8'h82;
	localparam logic [7:0] ADDR_SD_TWO = 8'h83;
	localparam logic [7:0] ADDR_WORK = 8'hff;
	localparam logic [11:0] RESET_VEC = 12'h0ffe;
	localparam logic [11:0] NMI_VEC = 12'h0ffc;
	localparam logic [11:0] INT_VEC_BASE = 12'h0ff0;
	localparam logic [7:0] RESET_DATA = 8'h00;
	localparam int STACK_DEPTH = 6;

	typedef enum logic [1:0] {
		CSREG_CTX_NORMAL = 2'b00,
		CSREG_CTX_INT = 2'b01,
		CSREG_CTX_NMI = 2'b10
	} csreg_ctx_t;

	typedef enum logic [3:0] {
		CSREG_PC_HOLD = 4'h0,
		CSREG_PC_INC = 4'h1,
		CSREG_PC_JUMP = 4'h2,
		CSREG_PC_CALL = 4'h3,
		CSREG_PC_BRANCH = 4'h4,
		CSREG_PC_INT = 4'h5,
		CSREG_PC_NMI = 4'h6,
		CSREG_PC_RET = 4'h7,
		CSREG_PC_RETURN_FROM_INTERRUPT_OP = 4'h8
	} csreg_pc_op_t;
endpackage

// File: csreg_stack.sv
// Purpose: six-level return stack outside data space
// Assumes: push and pop never in the same cycle
// Notes: overflow drops the oldest entry, empty pop changes nothing
`timescale 1ns/1ps
`default_nettype none
module csreg_stack #(
	parameter int DEPTH = csreg_pkg::STACK_DEPTH,
	parameter int WIDTH = csreg_pkg::PC_W
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// stack operations
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic [WIDTH-1:0] push_data_i,
	// stack state
	output logic [WIDTH-1:0] top_o,
	output logic empty_o
);
	localparam int CNT_W = $clog2(DEPTH + 1);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] lvl;
		logic [CNT_W-1:0] cnt;
		logic empty;
	} csreg_stk_t;

	csreg_stk_t st_r;
	csreg_stk_t st_nxt;

	initial begin
		if (DEPTH < 2)
			$error("stack depth below two");
	end

	always_comb begin
		st_nxt = st_r;
		if (push_i) begin
			for (int i = DEPTH - 1; i > 0; i--) begin
				st_nxt.lvl[i] = st_r.lvl[i-1];
			end
			st_nxt.lvl[0] = push_data_i;
			if (st_r.cnt != CNT_W'(DEPTH))
				st_nxt.cnt = st_r.cnt + CNT_W'(1);
		end else if (pop_i && !st_r.empty) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				st_nxt.lvl[i] = st_r.lvl[i+1];
			end
			st_nxt.cnt = st_r.cnt - CNT_W'(1);
		end
		st_nxt.empty = (st_nxt.cnt == '0);
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_r <= '{lvl: '0, cnt: '0, empty: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign top_o = st_r.lvl[0];
	assign empty_o = st_r.empty;
endmodule
`default_nettype wire

// File: tb_csreg_core.sv
// Purpose: self-checking bench of the core register set
// Assumes: inputs change at falling edges
// Notes: one task per scenario
`timescale 1ns/1ps
`default_nettype none
module tb_csreg_core;
	logic clk_i = 1'b0, sys_rst_i = 1'b1;
	logic dbus_short_i, dbus_rd_i, dbus_wr_i, dbus_hit_o, carry_o, zero_o, h;
	logic alu_wr_i = 1'b0, flag_we_i = 1'b0, carry_i = 1'b0, zero_i = 1'b0;
	logic page_wr_i = 1'b0;
	logic [1:0] dbus_short_sel_i, ctx_o, int_sel_i = 2'h0, page_i = 2'h0;
	logic [7:0] dbus_addr_i, dbus_wdata_i, dbus_rdata_o, q;
	logic [7:0] branch_off_i = 8'h00, alu_result_i = 8'h00;
	logic [7:0] work_o, ptr_one_o, ptr_two_o, sd_one_o, sd_two_o;
	logic [3:0] pc_op_i = 4'h0;
	logic [11:0] pc_target_i = 12'h000, pc_o;
	logic [13:0] prog_addr_o;
	int error_cnt = 0, samples_checked = 0, cyc = 0;
	csreg_core csreg_core_i (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.dbus_addr_i(dbus_addr_i),
		.dbus_short_i(dbus_short_i),
		.dbus_short_sel_i(dbus_short_sel_i),
		.dbus_rd_i(dbus_rd_i),
		.dbus_wr_i(dbus_wr_i),
		.dbus_wdata_i(dbus_wdata_i),
		.dbus_rdata_o(dbus_rdata_o),
		.dbus_hit_o(dbus_hit_o),
		.alu_wr_i(alu_wr_i),
		.alu_result_i(alu_result_i),
		.flag_we_i(flag_we_i),
		.carry_i(carry_i),
		.zero_i(zero_i),
		.carry_o(carry_o),
		.zero_o(zero_o),
		.pc_op_i(pc_op_i),
		.pc_target_i(pc_target_i),
		.branch_off_i(branch_off_i),
		.int_sel_i(int_sel_i),
		.page_wr_i(page_wr_i),
		.page_i(page_i),
		.work_o(work_o),
		.ptr_one_o(ptr_one_o),
		.ptr_two_o(ptr_two_o),
		.sd_one_o(sd_one_o),
		.sd_two_o(sd_two_o),
		.pc_o(pc_o),
		.prog_addr_o(prog_addr_o),
		.ctx_o(ctx_o)
	);
	csreg_bus_model csreg_bus_model_i (.clk_i(clk_i),
		.dbus_addr_o(dbus_addr_i), .dbus_wdata_o(dbus_wdata_i),
		.dbus_short_sel_o(dbus_short_sel_i), .dbus_short_o(dbus_short_i),
		.dbus_rd_o(dbus_rd_i), .dbus_wr_o(dbus_wr_i),
		.dbus_rdata_i(dbus_rdata_o), .dbus_hit_i(dbus_hit_o));
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			results();
		end
	end
	task results;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [15:0] g, e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task op(input logic [3:0] o);
		pc_op_i = o;
		@(negedge clk_i);
		pc_op_i = 4'h0;
		@(negedge clk_i);
	endtask
	task fw(input logic c, z);
		{flag_we_i, carry_i, zero_i} = {1'b1, c, z};
		@(negedge clk_i);
		{flag_we_i, carry_i, zero_i} = {1'b0, ~c, ~z};
		@(negedge clk_i);
	endtask
	task t_reset;
		sys_rst_i = 1'b1;
		repeat (4) @(negedge clk_i);
		sys_rst_i = 1'b0;
		chk({ctx_o, carry_o, zero_o}, 4'h8);
		chk(pc_o, 12'h0ffe);
		$display("t_reset done");
	endtask
	task t_flags;
		fw(1'b1, 1'b0);
		chk({ctx_o, carry_o, zero_o}, 4'ha);
		op(4'h8);
		chk({ctx_o, carry_o, zero_o}, 4'h0);
		fw(1'b0, 1'b1);
		chk({ctx_o, carry_o, zero_o}, 4'h1);
		int_sel_i = 2'h1;
		op(4'h5);
		chk({ctx_o, carry_o, zero_o}, 4'h4);
		fw(1'b1, 1'b1);
		chk({ctx_o, carry_o, zero_o}, 4'h7);
		op(4'h8);
		chk({ctx_o, carry_o, zero_o}, 4'h1);
		op(4'h6);
		chk({ctx_o, carry_o, zero_o}, 4'ha);
		$display("t_flags done");
	endtask
	task t_regs;
		logic [7:0] a [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff};
		for (int i = 0; i < 5; i++) begin
			csreg_bus_model_i.acc(1'b1, 1'b0, 2'h0, a[i], 8'h10 + 8'(i), q, h);
			chk(h, 1'b1);
			csreg_bus_model_i.acc(1'b0, 1'b0, 2'h0, a[i], 8'h00, q, h);
			chk(q, 8'h10 + 8'(i));
		end
		chk({ptr_one_o, ptr_two_o}, 16'h1011);
		chk({sd_one_o, sd_two_o}, 16'h1213);
		chk(work_o, 8'h14);
		for (int i = 0; i < 4; i++) begin
			csreg_bus_model_i.acc(1'b1, 1'b1, 2'(i), 8'h00, 8'h40 + 8'(i), q, h);
			csreg_bus_model_i.acc(1'b0, 1'b0, 2'h0, 8'h80 + 8'(i), 8'h00, q, h);
			chk(q, 8'h40 + 8'(i));
		end
		csreg_bus_model_i.acc(1'b0, 1'b0, 2'h0, 8'h84, 8'h00, q, h);
		chk({h, q}, 9'h000);
		$display("t_regs done");
	endtask
	task t_alu;
		{alu_wr_i, alu_result_i} = {1'b1, 8'h5a};
		fork
			csreg_bus_model_i.acc(1'b1, 1'b0, 2'h0, 8'hff, 8'ha5, q, h);
			begin
				@(negedge clk_i);
				alu_wr_i = 1'b0;
			end
		join
		chk(work_o, 8'h5a);
		$display("t_alu done");
	endtask
	task t_pc;
		pc_target_i = 12'h0ffe;
		op(4'h2);
		chk(pc_o, 12'h0ffe);
		op(4'h1);
		op(4'h1);
		chk(pc_o, 12'h0000);
		branch_off_i = 8'hfd;
		op(4'h4);
		chk(pc_o, 12'h0ffd);
		branch_off_i = 8'h7f;
		op(4'h4);
		chk(pc_o, 12'h007c);
		for (int i = 0; i < 4; i++) begin
			int_sel_i = 2'(i);
			op(4'h5);
			chk(pc_o, 12'h0ff0 + 12'(2 * i));
		end
		op(4'h6);
		chk(pc_o, 12'h0ffc);
		$display("t_pc done");
	endtask
	task t_stack;
		pc_target_i = 12'h0200;
		op(4'h2);
		for (int i = 0; i < 7; i++) begin
			pc_target_i = 12'h0100 + 12'(i);
			op(4'h3);
		end
		for (int i = 5; i >= 0; i--) begin
			op(4'h7);
			chk(pc_o, 12'h0100 + 12'(i));
		end
		op(4'h7);
		chk(pc_o, 12'h0101);
		$display("t_stack done");
	endtask
	task t_page;
		pc_target_i = 12'h0123;
		op(4'h2);
		{page_wr_i, page_i} = 3'h6;
		@(negedge clk_i);
		{page_wr_i, page_i} = 3'h1;
		@(negedge clk_i);
		chk(prog_addr_o, 14'h2123);
		$display("t_page done");
	endtask
	initial begin
		t_reset();
		t_flags();
		t_regs();
		t_alu();
		t_pc();
		t_stack();
		t_page();
		t_reset();
		results();
	end
endmodule
`default_nettype wire
